// File: logic/ufs_fifo_status.sv
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "ufs_defs.svh"
// Overview of operation
// [R1] Peek read returns head, FIFO unchanged
// [R2] Pop read returns head and removes it
// [R3] Software reads only after nonempty flag
// [R4] Software uses whole-word accesses only
// [R5] Host status codes; three raise events
// [R6] Device status codes; three raise events
// [R7] Data PID encoded DATA0/1/2/MDATA
// [R8] Bits 14:4 carry byte count
// [R9] Low nibble: channel or endpoint number
// [R10] Receive depth register, resets to 512
// [R11] Host: np depth high, start low
// [R12] Device: ep0 depth high, start low
// [R13] Shared length register resets 0x02000200
// [R14] Queue status invalid in device mode
// [R15] Top entry: channel, type, terminate
// [R16] Bits 23:16 free queue entries
// [R17] Low half free transmit words
// [R18] Queue status resets to 8 and 512
// [R19] Software writes reserved bits as reset
// [R20] Nonempty interrupt gated by enable bit 4
// [R21] Pop on empty leaves pointers unchanged
module ufs_fifo_status
    import ufs_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic HOST_MODE,
    input wire logic RX_PUSH,
    input wire logic [3:0] RX_PACKET_STATUS,
    input wire logic [1:0] RX_DATA_PID,
    input wire logic [10:0] RX_BYTE_COUNT,
    input wire logic [3:0] RX_NUMBER,
    output logic RX_PUSH_READY,
    output logic RX_FIFO_NONEMPTY_FLAG,
    output logic RX_FIFO_IRQ,
    output logic RX_POP_EVENT,
    input wire logic NPQ_PUSH,
    input wire logic NPQ_POP,
    input wire logic [6:0] NPQ_TOP_ENTRY,
    input wire logic NPTX_WORD_IN,
    input wire logic NPTX_WORD_OUT,
    output logic [15:0] RX_FIFO_DEPTH,
    output logic [31:0] NP_TX_FIFO_LENGTH
);

    // =================================================================
    // Bus decode
    logic addr_phase;
    logic wr_pend_reg;
    logic [`UFS_ADDR_BITS-1:0] wr_addr_reg;
    logic [`UFS_ADDR_BITS-1:0] a_addr;
    logic rd_take;
    logic pop_req;

    assign addr_phase = HSEL && HTRANS[1] && HREADY;
    assign a_addr = HADDR[`UFS_ADDR_BITS-1:0];
    assign rd_take = addr_phase && !HWRITE;
    assign pop_req = rd_take && (a_addr == `UFS_OFS_RX_STATUS_POP);

    // Zero wait states: read data is latched at the address phase edge
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // HSIZE is not decoded: every access is taken as a whole word
    // Write address is kept for the data phase, when HWDATA arrives
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= addr_phase && HWRITE;
            wr_addr_reg <= a_addr;
        end
    end

    // =================================================================
    // Writable registers
    logic [15:0] rx_len_reg;
    logic [15:0] rx_len_next;
    logic [31:0] np_len_reg;
    logic [31:0] np_len_next;
    logic irq_en_reg;
    logic irq_en_next;

    // Next values are forwarded to the read mux so back-to-back
    // write then read of the same register sees the new value.
    always_comb begin
        rx_len_next = rx_len_reg;
        np_len_next = np_len_reg;
        irq_en_next = irq_en_reg;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `UFS_OFS_RX_FIFO_LENGTH: rx_len_next = HWDATA[15:0]; // [R10]
                `UFS_OFS_NP_TX_FIFO_LENGTH: np_len_next = HWDATA; // [R11] [R12]
                `UFS_OFS_INT_ENABLE: irq_en_next = HWDATA[`UFS_RXF_NE_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_len_reg <= `UFS_RST_RX_FIFO_LENGTH; // [R10]
            np_len_reg <= `UFS_RST_NP_TX_FIFO_LENGTH; // [R13]
            irq_en_reg <= 1'b0;
        end else begin
            rx_len_reg <= rx_len_next;
            np_len_reg <= np_len_next;
            irq_en_reg <= irq_en_next;
        end
    end

    assign RX_FIFO_DEPTH = rx_len_reg;
    assign NP_TX_FIFO_LENGTH = np_len_reg;

    // =================================================================
    // Receive status FIFO
    // Sixteen entries is a fixed choice; the length register only
    // reports the software view of the receive RAM and sizes nothing here
    ufs_rx_entry_t rx_mem [`UFS_RX_DEPTH];
    logic [`UFS_RX_PTR_BITS-1:0] rx_wr_ptr_reg;
    logic [`UFS_RX_PTR_BITS-1:0] rx_rd_ptr_reg;
    logic [`UFS_RX_PTR_BITS:0] rx_count_reg;
    logic rx_full;
    logic rx_empty;
    logic rx_push_ok;
    logic rx_pop_ok;
    ufs_rx_entry_t rx_head;
    ufs_rx_entry_t rx_in;

    assign rx_full = (rx_count_reg == (`UFS_RX_PTR_BITS+1)'(`UFS_RX_DEPTH));
    assign rx_empty = (rx_count_reg == '0);
    assign rx_push_ok = RX_PUSH && !rx_full;
    assign rx_pop_ok = pop_req && !rx_empty; // [R21]
    assign RX_PUSH_READY = !rx_full;
    assign rx_head = rx_empty ? '0 : rx_mem[rx_rd_ptr_reg];

    // Fields arrive on separate ports and are packed in entry order
    always_comb begin
        rx_in = '0;
        rx_in[`UFS_RXE_STATUS_HI:`UFS_RXE_STATUS_LO] = RX_PACKET_STATUS; // [R5] [R6]
        rx_in[`UFS_RXE_DATA_PID_FIELD_HI:`UFS_RXE_DATA_PID_FIELD_LO] = RX_DATA_PID; // [R7]
        rx_in[`UFS_RXE_PACKET_BYTE_COUNT_HI:`UFS_RXE_PACKET_BYTE_COUNT_LO] = RX_BYTE_COUNT; // [R8]
        rx_in[`UFS_RXE_NUM_HI:`UFS_RXE_NUM_LO] = RX_NUMBER; // [R9]
    end

    always_ff @(posedge CLK) begin
        if (rx_push_ok) begin
            rx_mem[rx_wr_ptr_reg] <= rx_in;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_wr_ptr_reg <= '0;
            rx_rd_ptr_reg <= '0;
            rx_count_reg <= '0;
        end else begin
            if (rx_push_ok) begin
                rx_wr_ptr_reg <= rx_wr_ptr_reg + 1'b1;
            end
            if (rx_pop_ok) begin
                rx_rd_ptr_reg <= rx_rd_ptr_reg + 1'b1; // [R2]
            end
            // A push and a pop in one cycle leave the count alone
            if (rx_push_ok && !rx_pop_ok) begin
                rx_count_reg <= rx_count_reg + 1'b1;
            end else if (rx_pop_ok && !rx_push_ok) begin
                rx_count_reg <= rx_count_reg - 1'b1;
            end
        end
    end

    assign RX_FIFO_NONEMPTY_FLAG = !rx_empty;
    assign RX_FIFO_IRQ = !rx_empty && irq_en_reg; // [R20]

    // =================================================================
    // Head entry fields
    logic [3:0] head_status;
    ufs_pid_t head_pid;
    logic [10:0] head_byte_count;
    logic [3:0] head_number;
    logic [31:0] head_word;

    // An empty FIFO shows an all-zero head, so its fields read as zero
    assign head_status = rx_head[`UFS_RXE_STATUS_HI:`UFS_RXE_STATUS_LO]; // [R5] [R6]
    assign head_pid = ufs_pid_t'(rx_head[`UFS_RXE_DATA_PID_FIELD_HI:`UFS_RXE_DATA_PID_FIELD_LO]); // [R7]
    assign head_byte_count = rx_head[`UFS_RXE_PACKET_BYTE_COUNT_HI:`UFS_RXE_PACKET_BYTE_COUNT_LO]; // [R8]
    assign head_number = rx_head[`UFS_RXE_NUM_HI:`UFS_RXE_NUM_LO]; // [R9]
    assign head_word = {11'h000, head_status, head_pid, head_byte_count, head_number};

    // =================================================================
    // Pop events for interrupt-raising status codes
    logic pop_raises;
    logic pop_event_reg;

    // The mode is taken at pop time, so an entry pushed in one mode
    // and popped in the other is decoded by the newer mode
    always_comb begin
        pop_raises = 1'b0;
        if (HOST_MODE) begin
            case (head_status)
                UFS_H_IN_DONE, UFS_H_TOGGLE_ERR, UFS_H_CH_HALTED: pop_raises = 1'b1; // [R5]
                default: pop_raises = 1'b0;
            endcase
        end else begin
            case (head_status)
                UFS_D_GLOBAL_OUT_NAK, UFS_D_OUT_DONE, UFS_D_SETUP_DONE: pop_raises = 1'b1; // [R6]
                default: pop_raises = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pop_event_reg <= 1'b0;
        end else begin
            pop_event_reg <= rx_pop_ok && pop_raises;
        end
    end

    // Registered so the pulse cannot glitch with the head mux
    assign RX_POP_EVENT = pop_event_reg;

    // =================================================================
    // Non-periodic request queue and transmit FIFO space
    logic [3:0] npq_used;
    logic [15:0] nptx_used;
    logic [3:0] npq_free;
    logic [15:0] nptx_free;
    logic [15:0] np_depth;

    // The transmit ceiling follows the programmed depth, not a fixed size
    assign np_depth = np_len_reg[31:16];

    // Request queue slots in use, held between empty and eight
    ufs_sat_counter #(
        .WIDTH(4)
    ) u_npq_level (
        .clk(CLK),
        .rst(RST),
        .up(NPQ_PUSH),
        .down(NPQ_POP),
        .ceiling(`UFS_NPQ_DEPTH),
        .count(npq_used)
    );

    // Transmit words in use; a word beyond the depth is not counted
    ufs_sat_counter #(
        .WIDTH(16)
    ) u_nptx_level (
        .clk(CLK),
        .rst(RST),
        .up(NPTX_WORD_IN),
        .down(NPTX_WORD_OUT),
        .ceiling(np_depth),
        .count(nptx_used)
    );

    // Shrinking the depth below the fill level reads as full, not wrapped
    assign npq_free = `UFS_NPQ_DEPTH - npq_used; // [R16]
    assign nptx_free = (nptx_used >= np_depth) ? 16'h0000 :
        np_depth - nptx_used; // [R17]

    logic [31:0] qstat;
    always_comb begin
        qstat = '0;
        qstat[`UFS_QS_TOP_HI:`UFS_QS_TOP_LO] = NPQ_TOP_ENTRY; // [R15]
        qstat[`UFS_QS_SPACE_HI:`UFS_QS_SPACE_LO] = {4'h0, npq_free}; // [R16] [R18]
        qstat[15:0] = nptx_free; // [R17] [R18]
    end

    // =================================================================
    // Status words for the read mux
    logic [31:0] irq_en_word;
    logic [31:0] flags_word;
    logic [31:0] qstat_word;

    // Only the nonempty bits exist; every other position reads as zero
    always_comb begin
        irq_en_word = 32'h00000000;
        irq_en_word[`UFS_RXF_NE_BIT] = irq_en_next; // [R20]
        flags_word = 32'h00000000;
        flags_word[`UFS_RXF_NE_BIT] = !rx_empty;
    end

    // Device mode has no request queue, so the word reads as zero
    assign qstat_word = HOST_MODE ? qstat : 32'h00000000; // [R14]

    // =================================================================
    // Read mux
    logic [31:0] rd_value;
    logic [31:0] hrdata_reg;

    // Data is captured at the address phase edge, so the pop and the
    // load of HRDATA fall on one edge and the entry cannot be lost

    always_comb begin
        rd_value = 32'h00000000;
        case (a_addr)
            `UFS_OFS_RX_STATUS_PEEK: rd_value = head_word; // [R1]
            `UFS_OFS_RX_STATUS_POP: rd_value = head_word; // [R2]
            `UFS_OFS_RX_FIFO_LENGTH: rd_value = {16'h0000, rx_len_next};
            `UFS_OFS_NP_TX_FIFO_LENGTH: rd_value = np_len_next;
            `UFS_OFS_NP_TX_QUEUE_STATUS: rd_value = qstat_word; // [R14]
            `UFS_OFS_INT_ENABLE: rd_value = irq_en_word;
            `UFS_OFS_GLOBAL_INT_FLAGS: rd_value = flags_word;
            default: rd_value = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd_take) begin
            hrdata_reg <= rd_value;
        end
    end

    assign HRDATA = hrdata_reg;

endmodule

// =================================================================
// Up/down counter that stops at zero and at a ceiling
module ufs_sat_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic up,
    input wire logic down,
    input wire logic [WIDTH-1:0] ceiling,
    output logic [WIDTH-1:0] count
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic at_ceiling;
    logic at_floor;

    // An up and a down in one cycle cancel, so the level never moves
    assign at_ceiling = (count_reg >= ceiling);
    assign at_floor = (count_reg == '0);

    always_comb begin
        count_next = count_reg;
        if (up && !down && !at_ceiling) begin
            count_next = count_reg + WIDTH'(1);
        end else if (down && !up && !at_floor) begin
            count_next = count_reg - WIDTH'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule

// File: logic/ufs_defs.svh
`ifndef UFS_DEFS_SVH
`define UFS_DEFS_SVH

// =====================================================================
// Register byte offsets
`define UFS_OFS_INT_ENABLE 12'h018
`define UFS_OFS_RX_STATUS_PEEK 12'h01c
`define UFS_OFS_RX_STATUS_POP 12'h020
`define UFS_OFS_RX_FIFO_LENGTH 12'h024
`define UFS_OFS_NP_TX_FIFO_LENGTH 12'h028
`define UFS_OFS_NP_TX_QUEUE_STATUS 12'h02c
`define UFS_OFS_GLOBAL_INT_FLAGS 12'h030
`define UFS_ADDR_BITS 12

// =====================================================================
// Reset values
`define UFS_RST_INT_ENABLE 32'h00000000
`define UFS_RST_RX_FIFO_LENGTH 16'h0200
`define UFS_RST_NP_TX_FIFO_LENGTH 32'h02000200
`define UFS_RST_NP_TX_QUEUE_STATUS 32'h00080200

// =====================================================================
// Field positions
`define UFS_RXE_STATUS_HI 20
`define UFS_RXE_STATUS_LO 17
`define UFS_RXE_DATA_PID_FIELD_HI 16
`define UFS_RXE_DATA_PID_FIELD_LO 15
`define UFS_RXE_PACKET_BYTE_COUNT_HI 14
`define UFS_RXE_PACKET_BYTE_COUNT_LO 4
`define UFS_RXE_NUM_HI 3
`define UFS_RXE_NUM_LO 0
`define UFS_RXE_BITS 21
`define UFS_RXF_NE_BIT 4
`define UFS_QS_TOP_HI 30
`define UFS_QS_TOP_LO 24
`define UFS_QS_SPACE_HI 23
`define UFS_QS_SPACE_LO 16

// =====================================================================
// Sizes
`define UFS_RX_DEPTH 16
`define UFS_RX_PTR_BITS 4
`define UFS_NPQ_DEPTH 4'h8

`endif

// File: logic/ufs_pkg.sv
package ufs_pkg;

    typedef logic [20:0] ufs_rx_entry_t;

    typedef enum logic [3:0] {
        UFS_H_IN_DATA = 4'h2,
        UFS_H_IN_DONE = 4'h3,
        UFS_H_TOGGLE_ERR = 4'h5,
        UFS_H_CH_HALTED = 4'h7
    } ufs_host_status_t;

    typedef enum logic [3:0] {
        UFS_D_GLOBAL_OUT_NAK = 4'h1,
        UFS_D_OUT_DATA = 4'h2,
        UFS_D_OUT_DONE = 4'h3,
        UFS_D_SETUP_DONE = 4'h4,
        UFS_D_SETUP_DATA = 4'h6
    } ufs_dev_status_t;

    typedef enum logic [1:0] {
        UFS_PID_DATA0 = 2'h0,
        UFS_PID_DATA2 = 2'h1,
        UFS_PID_DATA1 = 2'h2,
        UFS_PID_MDATA = 2'h3
    } ufs_pid_t;

endpackage

// File: sim/ufs_fifo_status_props.sv
`timescale 1ns/1ps
// =====================================================
// Checker on the top ports
module ufs_fifo_status_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HOST_MODE,
    input wire logic RX_PUSH,
    input wire logic RX_FIFO_NONEMPTY_FLAG,
    input wire logic RX_FIFO_IRQ,
    input wire logic RX_POP_EVENT,
    input wire logic [15:0] RX_FIFO_DEPTH,
    input wire logic [31:0] NP_TX_FIFO_LENGTH
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire rd = HSEL && HTRANS[1] && HREADY && !HWRITE;
    wire rd_pk = rd && HADDR[11:0] == 12'h01c;
    wire rd_pop = rd && HADDR[11:0] == 12'h020;
    AST_RST_LEN: assert property ($fell(RST) |-> RX_FIFO_DEPTH == 16'h0200
        && NP_TX_FIFO_LENGTH == 32'h02000200) else $error("length reset value wrong");
    AST_IRQ_GATE: assert property (RX_FIFO_IRQ |-> RX_FIFO_NONEMPTY_FLAG)
        else $error("irq without entry");
    AST_PUSH_FLAG: assert property (RX_PUSH && !rd_pop |=> RX_FIFO_NONEMPTY_FLAG)
        else $error("push left fifo empty");
    AST_PEEK_KEEP: assert property (rd_pk && RX_FIFO_NONEMPTY_FLAG |=>
        RX_FIFO_NONEMPTY_FLAG) else $error("peek emptied fifo");
    AST_POP_EVENT: assert property (RX_POP_EVENT |-> $past(rd_pop) || $past(rd_pop, 2))
        else $error("pop event without pop");
    AST_HOLD_DATA: assert property (!rd |=> $stable(HRDATA))
        else $error("read data moved without read");
    AST_QS_DEV: assert property (rd && HADDR[11:0] == 12'h02c && !HOST_MODE |=>
        HRDATA == 32'h0) else $error("queue status nonzero in device mode");
    AST_RXLEN_RSV: assert property (rd && HADDR[11:0] == 12'h024 |=>
        HRDATA[31:16] == 16'h0) else $error("rx length upper half nonzero");
    AST_ENTRY_RSV: assert property (rd_pk || rd_pop |=> HRDATA[31:21] == 11'h0)
        else $error("entry reserved bits set");
    AST_POP_EMPTY: assert property (rd_pop && !RX_FIFO_NONEMPTY_FLAG && !RX_PUSH
        |=> HRDATA == 32'h0 && !RX_FIFO_NONEMPTY_FLAG) else $error("pop on empty");
endmodule

bind ufs_fifo_status ufs_fifo_status_chk u_chk (.CLK(CLK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HOST_MODE(HOST_MODE), .RX_PUSH(RX_PUSH), .RX_FIFO_NONEMPTY_FLAG(RX_FIFO_NONEMPTY_FLAG),
    .RX_FIFO_IRQ(RX_FIFO_IRQ), .RX_POP_EVENT(RX_POP_EVENT), .RX_FIFO_DEPTH(RX_FIFO_DEPTH),
    .NP_TX_FIFO_LENGTH(NP_TX_FIFO_LENGTH));

// File: sim/ufs_usb_partner.sv
`timescale 1ns/1ps
// =====================================================
// Far side: hands received packet entries in
module ufs_usb_partner (
    input wire logic clk,
    input wire logic push_ready,
    output logic push,
    output logic [20:0] entry
);
    initial begin
        push = 1'b0;
        entry = 21'h0;
    end
    task automatic send(input logic [20:0] e);
        int n;
        n = 0;
        while (push_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        push <= 1'b1;
        entry <= e;
        @(posedge clk);
        push <= 1'b0;
        // Fields are meaningless once the strobe drops
        entry <= ~e;
        @(posedge clk);
    endtask
endmodule

// File: sim/tb_ufs_fifo_status.sv
`timescale 1ns/1ps
module tb_ufs_fifo_status import ufs_pkg::*;;
    logic CLK = 0, RST = 1, hsel = 0, hwrite = 0, host = 1;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd, e, ev = 0;
    logic [3:0] npv = 0;
    logic [6:0] top = 0;
    logic [3:0] codes [9] = '{4'h2, 4'h3, 4'h5, 4'h7, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
    logic [20:0] ent;
    logic [31:0] rd_w, nplen;
    logic [15:0] depth;
    logic push, ready, ne, irq, pev, hro, hresp;
    int bad_count = 0, check_count = 0, cyc = 0;
    ufs_usb_partner usb (.clk(CLK), .push_ready(ready), .push(push), .entry(ent));
    ufs_fifo_status dut (.CLK(CLK), .RST(RST), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hro), .HRDATA(rd_w),
        .HREADYOUT(hro), .HRESP(hresp), .HOST_MODE(host), .RX_PUSH(push),
        .RX_PACKET_STATUS(ent[20:17]), .RX_DATA_PID(ent[16:15]), .RX_BYTE_COUNT(ent[14:4]),
        .RX_NUMBER(ent[3:0]), .RX_PUSH_READY(ready), .RX_FIFO_NONEMPTY_FLAG(ne),
        .RX_FIFO_IRQ(irq), .RX_POP_EVENT(pev), .NPQ_PUSH(npv[0]), .NPQ_POP(npv[1]),
        .NPQ_TOP_ENTRY(top), .NPTX_WORD_IN(npv[2]), .NPTX_WORD_OUT(npv[3]),
        .RX_FIFO_DEPTH(depth), .NP_TX_FIFO_LENGTH(nplen));
    initial forever #25 CLK = ~CLK;
    // =====================================================
    // Tasks
    task automatic finish_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        n = 0;
        do @(posedge CLK); while (hro !== 1'b1 && ++n < 9);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        n = 0;
        do @(posedge CLK); while (hro !== 1'b1 && ++n < 9);
        rd = rd_w;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, x);
    endtask
    task automatic np(input int b, input int k);
        repeat (k) begin
            @(posedge CLK);
            npv[b] <= 1'b1;
            @(posedge CLK);
            npv[b] <= 1'b0;
        end
    endtask
    // Hang guard and pop event tally
    always @(posedge CLK) begin
        cyc++;
        if (!RST && pev === 1'b1) ev <= ev + 1;
        if (cyc == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    // =====================================================
    // Sequence
    initial begin
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        rdc("rx_len", 12'h024, 32'h00000200);
        rdc("np_len", 12'h028, 32'h02000200);
        rdc("qstat", 12'h02c, 32'h00080200);
        rdc("pop_empty", 12'h020, 32'h0);
        rdc("unmapped", 12'h040, 32'h0);
        chk("hresp", 32'(hresp), 32'h0);
        bus(1'b1, 12'h024, 32'h00000010);
        rdc("rx_len_w", 12'h024, 32'h00000010);
        chk("depth_port", 32'(depth), 32'h00000010);
        bus(1'b1, 12'h028, 32'h00100040);
        rdc("np_len_w", 12'h028, 32'h00100040);
        chk("np_len_port", nplen, 32'h00100040);
        top <= 7'h5b;
        np(0, 9);
        np(2, 3);
        rdc("qstat_full", 12'h02c, 32'h5b00000d);
        np(1, 2);
        np(2, 14);
        rdc("qstat_pop", 12'h02c, 32'h5b020000);
        host <= 1'b0;
        rdc("qstat_dev", 12'h02c, 32'h0);
        for (int i = 0; i < 9; i++) begin
            host <= (i < 4);
            e = {11'h0, codes[i], i[1:0], 11'h7ff - i[10:0], i[3:0]};
            usb.send(e[20:0]);
            chk("nonempty", 32'(ne), 32'h1);
            rdc("peek", 12'h01c, e);
            rdc("peek2", 12'h01c, e);
            rdc("pop", 12'h020, e);
            rdc("after_pop", 12'h01c, 32'h0);
        end
        chk("pop_events", ev, 32'h6);
        bus(1'b1, 12'h018, 32'h10);
        usb.send(21'h040000);
        chk("irq_on", 32'(irq), 32'h1);
        rdc("gflags", 12'h030, 32'h10);
        bus(1'b1, 12'h018, 32'h0);
        @(posedge CLK);
        chk("irq_off", 32'(irq), 32'h0);
        rdc("pop_last", 12'h020, 32'h00040000);
        for (int k = 0; k < 16; k++) begin
            usb.send({4'h2, 2'h2, 11'(k), 4'(k)});
        end
        chk("full_ready", 32'(ready), 32'h0);
        for (int k = 0; k < 16; k++) begin
            rdc("pop_fill", 12'h020, {11'h0, 4'h2, 2'h2, 11'(k), 4'(k)});
        end
        chk("drained", 32'(ne), 32'h0);
        finish_test();
    end
endmodule
